/* rtl/eiu_top.sv */
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module eiu_top (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire eiu_pkg::eiu_bus_t BUS,
  output logic [31:0] RDATA,
  input wire logic [eiu_pkg::NPIN-1:0] PINS,
  input wire logic NMI_PIN,
  input wire logic ULP_TICK,
  input wire logic STANDBY,
  output logic [eiu_pkg::NPIN-1:0] EVENTS,
  output logic IRQ,
  output logic NMI_IRQ
);
  localparam int NCH = eiu_pkg::NCH;
  localparam int NPIN = eiu_pkg::NPIN;

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] w, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = w[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic detect(input logic [2:0] s, input logic p,
      input logic c);
    case (eiu_pkg::eiu_sense_t'(s))
      eiu_pkg::SENSE_RISE: detect = !p && c;
      eiu_pkg::SENSE_FALL: detect = p && !c;
      eiu_pkg::SENSE_BOTH: detect = p ^ c;
      eiu_pkg::SENSE_HIGH: detect = c;
      eiu_pkg::SENSE_LOW: detect = !c;
      default: detect = 1'b0;
    endcase
  endfunction : detect

  logic [31:0] ctrl_q, ctrl_d, nmicfg_q, nmicfg_d, mask_q, mask_d;
  logic [31:0] async_q, async_d, config_q, config_d, rdata_q, rdata_d;
  logic [NPIN-1:0] flag_q, flag_d, evt_q, evt_d;
  logic nmif_q, nmif_d, irq_q, irq_d;
  logic [2:0] hist_q [NCH];
  logic [2:0] hist_d [NCH];
  logic [NCH-1:0] lvl_q, lvl_d, raw_q, armed_q, armed_d, hit, ev;
  logic [NCH-1:0] pins, async_all;
  logic [4*NCH-1:0] cfg_all;
  logic [2:0] sense;
  logic filt, cur, edge_s, tick, en, enabling, nmi_chg;

  always_comb begin
    ctrl_d = ctrl_q;
    nmicfg_d = nmicfg_q;
    mask_d = mask_q;
    async_d = async_q;
    config_d = config_q;
    flag_d = flag_q;
    nmif_d = nmif_q;
    rdata_d = eiu_pkg::RST_WORD;
    sense = 3'h0;
    filt = 1'b0;
    cur = 1'b0;
    edge_s = 1'b0;
    // slow tick paces sampling, clock stays single
    tick = ctrl_q[eiu_pkg::CTRL_CLOCK_SELECT] ? ULP_TICK : 1'b1;
    en = ctrl_q[eiu_pkg::CTRL_EN];
    if (BUS.wr) begin
      if (BUS.addr == eiu_pkg::OFS_CTRL) begin
        ctrl_d = merge(ctrl_q, BUS.wdata, BUS.be) & eiu_pkg::CTRL_WMASK;
      end else if (BUS.addr == eiu_pkg::OFS_NMICFG) begin
        nmicfg_d = merge(nmicfg_q, BUS.wdata, BUS.be) & eiu_pkg::NMICFG_WMASK;
      end else if (BUS.addr == eiu_pkg::OFS_MASK) begin
        mask_d = merge(mask_q, BUS.wdata, BUS.be) & eiu_pkg::MASK_WMASK;
      end else if (BUS.addr == eiu_pkg::OFS_ASYNC) begin
        case (BUS.be)
          4'h1: async_d = {4{BUS.wdata[7:0]}};
          4'h2: async_d = {4{BUS.wdata[15:8]}};
          4'h4: async_d = {4{BUS.wdata[23:16]}};
          4'h8: async_d = {4{BUS.wdata[31:24]}};
          4'h3: async_d = {2{BUS.wdata[15:0]}};
          4'hc: async_d = {2{BUS.wdata[31:16]}};
          default: async_d = merge(async_q, BUS.wdata, BUS.be);
        endcase
      end else if (BUS.addr == eiu_pkg::OFS_CONFIG) begin
        config_d = merge(config_q, BUS.wdata, BUS.be);
      end else if (BUS.addr == eiu_pkg::OFS_FLAG) begin
        flag_d = flag_q & ~(BUS.wdata[7:0] & {8{BUS.be[0]}});
      end else if (BUS.addr == eiu_pkg::OFS_NONMASKABLE_FLAG) begin
        nmif_d = nmif_q & ~(BUS.wdata[0] & BUS.be[0]);
      end
    end
    enabling = ctrl_d[eiu_pkg::CTRL_EN] && !en;
    // sense change under a running unit glitches the nmi detector
    nmi_chg = BUS.wr && BUS.addr == eiu_pkg::OFS_NMICFG && en &&
              nmicfg_d[2:0] != nmicfg_q[2:0];
    pins = {NMI_PIN, PINS};
    cfg_all = {nmicfg_q[3:0], config_q};
    async_all = {1'b0, async_q[NPIN-1:0]};
    for (int i = 0; i < NCH; i++) begin
      sense = cfg_all[eiu_pkg::CFG_W*i +: 3];
      filt = cfg_all[eiu_pkg::CFG_W*i + eiu_pkg::CFG_FILT];
      hist_d[i] = tick ? {hist_q[i][1:0], pins[i]} : hist_q[i];
      cur = filt ? ((hist_d[i][0] & hist_d[i][1]) |
                    (hist_d[i][0] & hist_d[i][2]) |
                    (hist_d[i][1] & hist_d[i][2])) : pins[i];
      lvl_d[i] = tick ? cur : lvl_q[i];
      edge_s = sense == 3'(eiu_pkg::SENSE_RISE) ||
               sense == 3'(eiu_pkg::SENSE_FALL) ||
               sense == 3'(eiu_pkg::SENSE_BOTH);
      if (async_all[i] && edge_s) begin
        hit[i] = en && detect(sense, raw_q[i], pins[i]);
      end else begin
        hit[i] = en && tick && detect(sense, lvl_q[i], cur);
      end
      // one async event per standby stay; flag still wakes the core
      ev[i] = hit[i] && !(async_all[i] && edge_s && STANDBY &&
              !armed_q[i]);
      armed_d[i] = !STANDBY ||
                   (armed_q[i] && !(hit[i] && async_all[i] && edge_s));
      if (enabling) begin
        // filter restarts from zero, hence the stray flag at enable
        hist_d[i] = eiu_pkg::RST_HIST;
        lvl_d[i] = filt ? 1'b0 : pins[i];
      end
    end
    // set wins over a same-cycle clear
    flag_d = flag_d | hit[NPIN-1:0];
    nmif_d = nmif_d | hit[NPIN] | nmi_chg;
    evt_d = ev[NPIN-1:0];
    irq_d = |(flag_d & mask_d[NPIN-1:0]);
    if (BUS.rd) begin
      if (BUS.addr == eiu_pkg::OFS_CTRL) begin
        rdata_d = ctrl_q;
      end else if (BUS.addr == eiu_pkg::OFS_NMICFG) begin
        rdata_d = nmicfg_q;
      end else if (BUS.addr == eiu_pkg::OFS_MASK) begin
        rdata_d = mask_q;
      end else if (BUS.addr == eiu_pkg::OFS_FLAG) begin
        rdata_d = {24'h0, flag_q};
      end else if (BUS.addr == eiu_pkg::OFS_NONMASKABLE_FLAG) begin
        rdata_d = {31'h0, nmif_q};
      end else if (BUS.addr == eiu_pkg::OFS_ASYNC) begin
        rdata_d = async_q;
      end else if (BUS.addr == eiu_pkg::OFS_CONFIG) begin
        rdata_d = config_q;
      end else if (BUS.addr == eiu_pkg::OFS_STATUS) begin
        rdata_d = {23'h0, lvl_q};
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_q <= eiu_pkg::RST_WORD;
      nmicfg_q <= eiu_pkg::RST_WORD;
      mask_q <= eiu_pkg::RST_WORD;
      async_q <= eiu_pkg::RST_WORD;
      config_q <= eiu_pkg::RST_WORD;
      rdata_q <= eiu_pkg::RST_WORD;
      flag_q <= '0;
      evt_q <= '0;
      nmif_q <= 1'b0;
      irq_q <= 1'b0;
      lvl_q <= '0;
      raw_q <= '0;
      armed_q <= eiu_pkg::RST_ARMED;
      for (int i = 0; i < NCH; i++) begin
        hist_q[i] <= eiu_pkg::RST_HIST;
      end
    end else if (CE) begin
      ctrl_q <= ctrl_d;
      nmicfg_q <= nmicfg_d;
      mask_q <= mask_d;
      async_q <= async_d;
      config_q <= config_d;
      rdata_q <= rdata_d;
      flag_q <= flag_d;
      evt_q <= evt_d;
      nmif_q <= nmif_d;
      irq_q <= irq_d;
      lvl_q <= lvl_d;
      raw_q <= pins;
      armed_q <= armed_d;
      for (int i = 0; i < NCH; i++) begin
        hist_q[i] <= hist_d[i];
      end
    end
  end

  assign RDATA = rdata_q;
  assign EVENTS = evt_q;
  assign IRQ = irq_q;
  assign NMI_IRQ = nmif_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  logic [7:0] a_wbyte;
  assign a_wbyte = BUS.wdata[7:0];

  sequence s_async_wr(logic [3:0] b);
    CE && BUS.wr && BUS.addr == eiu_pkg::OFS_ASYNC && BUS.be == b;
  endsequence
  sequence s_enable0;
    CE && BUS.wr && BUS.addr == eiu_pkg::OFS_CTRL && BUS.be[0] &&
    BUS.wdata[eiu_pkg::CTRL_EN] && !en &&
    config_q[7:4] == {1'b1, eiu_pkg::SENSE_LOW};
  endsequence
  sequence s_quiet_tick;
    CE && tick && !BUS.wr;
  endsequence

  a_byte_repl: assert property (
    s_async_wr(4'h1) |=> async_q == {4{$past(a_wbyte)}})
    else $error("byte write not copied to all lanes");
  a_half_repl: assert property (
    s_async_wr(4'h3) or s_async_wr(4'hc) |=>
      async_q[31:16] == async_q[15:0])
    else $error("halfword write not mirrored");
  a_spur_flag: assert property (
    s_enable0 ##1 s_quiet_tick |=> flag_q[1])
    else $error("filtered low sense gave no flag at enable");
  a_false_nmi: assert property (
    CE && nmi_chg |=> NMI_IRQ)
    else $error("sense change while running gave no nmi");
  a_standby_once: assert property (
    CE && STANDBY && async_q[2] && !armed_q[2] &&
    config_q[10:8] == 3'(eiu_pkg::SENSE_RISE) |=> !EVENTS[2])
    else $error("second async edge in standby made an event");
  a_sync_edge: assert property (
    CE && en && tick && !async_q[0] && !lvl_q[0] && PINS[0] &&
    config_q[3:0] == {1'b0, eiu_pkg::SENSE_RISE} |=>
      EVENTS[0] && flag_q[0])
    else $error("synchronous rising edge missed");
  a_ulp_pace: assert property (
    CE && ctrl_q[eiu_pkg::CTRL_CLOCK_SELECT] && !ULP_TICK && async_q == '0
    |=> EVENTS == '0)
    else $error("event without slow clock tick");
  a_flag_clear: assert property (
    CE && BUS.wr && BUS.addr == eiu_pkg::OFS_FLAG && BUS.be[0] &&
    BUS.wdata[0] |=> flag_q[0] == $past(hit[0]))
    else $error("flag write-one-clear or set priority wrong");
  a_irq_level: assert property (
    ##1 IRQ == |(flag_q & mask_q[NPIN-1:0]))
    else $error("irq does not follow masked flags");

  a_byte_lane1: assert property (
    s_async_wr(4'h2) |=> async_q == {4{$past(BUS.wdata[15:8])}})
    else $error("lane one byte not copied to all lanes");

  a_byte_lane2: assert property (
    s_async_wr(4'h4) |=> async_q == {4{$past(BUS.wdata[23:16])}})
    else $error("lane two byte not copied to all lanes");

  a_byte_lane3: assert property (
    s_async_wr(4'h8) |=> async_q == {4{$past(BUS.wdata[31:24])}})
    else $error("lane three byte not copied to all lanes");

  a_half_low: assert property (
    s_async_wr(4'h3) |=> async_q[31:16] == $past(BUS.wdata[15:0]))
    else $error("low half not copied upward");

  a_half_high: assert property (
    s_async_wr(4'hc) |=> async_q[15:0] == $past(BUS.wdata[31:16]))
    else $error("high half not copied downward");

  // first edge in standby must still get through
  a_standby_first: assert property (
    CE && en && STANDBY && armed_q[2] && async_q[2] && !raw_q[2] &&
    PINS[2] && config_q[10:8] == 3'(eiu_pkg::SENSE_RISE) |=> EVENTS[2])
    else $error("first async edge in standby made no event");

  a_nmi_clear: assert property (
    CE && BUS.wr && BUS.addr == eiu_pkg::OFS_NONMASKABLE_FLAG && BUS.be[0] &&
    BUS.wdata[0] && !hit[NPIN] |=> !NMI_IRQ)
    else $error("nonmaskable flag not cleared by write of one");

  a_off_quiet: assert property (
    CE && !en |=> EVENTS == '0)
    else $error("event from a disabled unit");

  a_ce_freeze: assert property (
    !CE |=> $stable(flag_q) && $stable(ctrl_q) && $stable(EVENTS))
    else $error("state moved while clock enable low");

  a_rdata_idle: assert property (
    CE && !BUS.rd |=> RDATA == '0)
    else $error("read data not zero outside a read");

  a_flag_read: assert property (
    CE && BUS.rd && BUS.addr == eiu_pkg::OFS_FLAG |=>
      RDATA == {24'h0, $past(flag_q)})
    else $error("flag read returned wrong value");

  a_mask_write: assert property (
    CE && BUS.wr && BUS.addr == eiu_pkg::OFS_MASK && BUS.be == 4'hf |=>
      mask_q == ($past(BUS.wdata) & eiu_pkg::MASK_WMASK))
    else $error("mask write not stored");
endmodule : eiu_top
`default_nettype wire

/* rtl/eiu_pkg.sv */
// Summary of operation
// - a byte write to async_edge_select copies that byte into all four lanes
// - a halfword write to async_edge_select copies it into both halves
// - enabling with filter on may set flags for low, rise, both senses
// - changing the nonmaskable sense while running raises a false request
// - async edges in standby give one event only, until wake-up
// - async_edge_select bit at zero selects clocked synchronous detection
// - clock_select at one paces synchronous detection from the ultra low power tick
package eiu_pkg;
  localparam int NPIN = 8;
  localparam int NCH = NPIN + 1;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_NMICFG = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_FLAG = 8'h0c;
  localparam logic [7:0] OFS_NONMASKABLE_FLAG = 8'h10;
  localparam logic [7:0] OFS_ASYNC = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam int CTRL_EN = 0;
  localparam int CTRL_CLOCK_SELECT = 1;
  localparam int CFG_W = 4;
  localparam int CFG_FILT = 3;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0003;
  localparam logic [31:0] NMICFG_WMASK = 32'h0000_000f;
  localparam logic [31:0] MASK_WMASK = 32'h0000_00ff;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [NCH-1:0] RST_ARMED = 9'h1ff;
  localparam logic [2:0] RST_HIST = 3'h0;
  typedef enum logic [2:0] {
    SENSE_NONE, SENSE_RISE, SENSE_FALL, SENSE_BOTH, SENSE_HIGH, SENSE_LOW
  } eiu_sense_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic wr;
    logic rd;
  } eiu_bus_t;
endpackage : eiu_pkg

/* bench/eiu_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eiu_pins_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] pin_cmd,
  input wire logic nmi_cmd,
  output logic [7:0] pins,
  output logic nmi,
  output logic tick
);
  logic [1:0] div_q;
  // slow oscillator stand-in, one pulse per 4 clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 2'h0;
      pins <= 8'h00;
      nmi <= 1'b0;
      tick <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      tick <= (div_q == 2'h3);
      pins <= pin_cmd;
      nmi <= nmi_cmd;
    end
  end
endmodule : eiu_pins_model
`default_nettype wire

/* bench/eiu_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module eiu_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stby = 1'b0;
  logic nmi_cmd = 1'b0;
  logic [7:0] pin_cmd = 8'h00;
  eiu_pkg::eiu_bus_t bus = '0;
  logic [31:0] rdata, rd_v;
  logic [7:0] pins, events;
  logic nmi, tick, irq, nmi_irq;
  int err_total = 0, compares = 0, cyc = 0, evc = 0, asy_m;
  always #12.5 clk = ~clk;
  eiu_pins_model eiu_pins_model_inst (.clk(clk), .rst(rst),
    .pin_cmd(pin_cmd), .nmi_cmd(nmi_cmd), .pins(pins), .nmi(nmi),
    .tick(tick));
  eiu_top eiu_top_inst (.CLK(clk), .SYS_RST(rst), .CE(1'b1), .BUS(bus),
    .RDATA(rdata), .PINS(pins), .NMI_PIN(nmi), .ULP_TICK(tick),
    .STANDBY(stby), .EVENTS(events), .IRQ(irq), .NMI_IRQ(nmi_irq));
  task automatic final_report;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (events[2] === 1'b1) evc <= evc + 1;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] be);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, be: be, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, be: 4'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 rd_v = rdata;
  endtask : rd
  task automatic wait_cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  initial begin
    logic [7:0] b;
    logic [15:0] h;
    void'($urandom(32'h8732fa9c));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a <= 32'h20; a += 4) begin
      rd(a[7:0]);
      chk("reset value", 32'h0, rd_v);
    end
    asy_m = 0;
    for (int l = 0; l < 4; l++) begin
      b = 8'($urandom());
      wr(eiu_pkg::OFS_ASYNC, {4{b}} ^ 32'h5a5a_5a5a, 4'h1 << l);
      b = b ^ 8'h5a;
      asy_m = {b, b, b, b};
      rd(eiu_pkg::OFS_ASYNC);
      chk("async byte", asy_m, rd_v);
    end
    for (int k = 0; k < 2; k++) begin
      h = 16'($urandom());
      wr(eiu_pkg::OFS_ASYNC, {h, h}, k ? 4'hc : 4'h3);
      asy_m = {h, h};
      rd(eiu_pkg::OFS_ASYNC);
      chk("async half", asy_m, rd_v);
    end
    wr(eiu_pkg::OFS_ASYNC, 32'h0, 4'hf);
    wr(eiu_pkg::OFS_CONFIG, 32'h0000_0001, 4'hf);
    wr(eiu_pkg::OFS_MASK, 32'h1, 4'hf);
    wr(eiu_pkg::OFS_CTRL, 32'h3, 4'hf);
    pin_cmd <= 8'h01;
    wait_cyc(20);
    chk("irq slow sync", 32'h1, irq);
    rd(eiu_pkg::OFS_FLAG);
    chk("flag sync", 32'h1, rd_v);
    wr(eiu_pkg::OFS_FLAG, 32'h1, 4'h1);
    rd(eiu_pkg::OFS_FLAG);
    chk("flag cleared", 32'h0, rd_v);
    wr(eiu_pkg::OFS_CTRL, 32'h0, 4'hf);
    pin_cmd <= 8'h03;
    wr(eiu_pkg::OFS_CONFIG, 32'h0000_00d1, 4'hf);
    wr(eiu_pkg::OFS_CTRL, 32'h1, 4'hf);
    wait_cyc(4);
    rd(eiu_pkg::OFS_FLAG);
    chk("spurious flag", 32'h2, rd_v & 32'h2);
    chk("masked irq", 32'h0, irq);
    wait_cyc(10);
    wr(eiu_pkg::OFS_FLAG, 32'h2, 4'h1);
    rd(eiu_pkg::OFS_FLAG);
    chk("flag after filter", 32'h0, rd_v);
    wr(eiu_pkg::OFS_NMICFG, 32'h1, 4'hf);
    wait_cyc(2);
    chk("false nmi", 32'h1, nmi_irq);
    wr(eiu_pkg::OFS_NONMASKABLE_FLAG, 32'h1, 4'h1);
    wait_cyc(2);
    chk("nmi cleared", 32'h0, nmi_irq);
    wr(eiu_pkg::OFS_ASYNC, 32'h4, 4'hf);
    wr(eiu_pkg::OFS_CONFIG, 32'h0000_01d1, 4'hf);
    stby <= 1'b1;
    evc = 0;
    for (int t = 0; t < 4; t++) begin
      pin_cmd <= pin_cmd ^ 8'h04;
      wait_cyc(6);
    end
    chk("standby events", 32'h1, evc);
    rd(eiu_pkg::OFS_FLAG);
    chk("standby flag", 32'h4, rd_v & 32'h4);
    stby <= 1'b0;
    final_report();
  end
endmodule : eiu_top_tb
`default_nettype wire
